// >>> rtl/lpmc_power_mode_ctrl.sv
`timescale 1ns/1ps
module lpmc_power_mode_ctrl (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire lpmc_pkg::lpmc_runcfg_t run_cfg_i,
    input wire logic sleep_deep_i,
    input wire logic wait_for_interrupt_insn_i,
    input wire logic wait_for_event_insn_i,
    input wire logic nested_vector_irq_ctrl_irq_pending_i,
    input wire logic async_wake_event_i,
    input wire logic clk_restarted_i,
    output lpmc_pkg::lpmc_mode_t mode_o,
    output lpmc_pkg::lpmc_ctrl_t ctrl_o,
    output logic eeprom_wr_block_o,
    output logic flash_cmd_block_o,
    output logic clk_restart_req_o
);

    // ****************************************
    // State
    // ****************************************
    lpmc_pkg::lpmc_state_t st;
    lpmc_pkg::lpmc_state_t next_st;

    // Whole state after reset; the sync chain restarts from zero
    localparam lpmc_pkg::lpmc_state_t ST_RST = '{
        mode: lpmc_pkg::LPMC_RUN,
        resume_mode: lpmc_pkg::LPMC_RUN,
        ctrl: lpmc_pkg::LPMC_CTRL_RST,
        eeprom_wr_block: 1'b0,
        flash_cmd_block: 1'b0,
        clk_restart_req: 1'b0,
        rst_sync: 2'h0
    };

    // ****************************************
    // Per-mode enables
    // ****************************************
    function automatic lpmc_pkg::lpmc_ctrl_t mode_ctrl(input lpmc_pkg::lpmc_mode_t m);
        lpmc_pkg::lpmc_ctrl_t c;
        c = lpmc_pkg::LPMC_CTRL_RST;
        case (m)
            lpmc_pkg::LPMC_RUN: begin
                c.core_clk_en = 1'b1;
                c.periph_clk_en = 1'b1;
                c.reduced_freq = 1'b0;
                c.nested_vector_irq_ctrl_clk_en = 1'b1;
                c.async_wake_irq_ctrl_en = 1'b0;
                c.lvd_en = 1'b1;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b1;
                c.osc_en = 1'b1;
                c.periodic_interval_timer_clk_en = 1'b1;
                c.flexible_io_unit_clk_en = 1'b1;
                c.serial_clk_en = 1'b1;
                c.dma_clk_en = 1'b1;
            end
            lpmc_pkg::LPMC_HS_RUN: begin
                c.core_clk_en = 1'b1;
                c.periph_clk_en = 1'b1;
                c.reduced_freq = 1'b0;
                c.nested_vector_irq_ctrl_clk_en = 1'b1;
                c.async_wake_irq_ctrl_en = 1'b0;
                c.lvd_en = 1'b1;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b1;
                c.osc_en = 1'b1;
                c.periodic_interval_timer_clk_en = 1'b1;
                c.flexible_io_unit_clk_en = 1'b1;
                c.serial_clk_en = 1'b1;
                c.dma_clk_en = 1'b1;
            end
            lpmc_pkg::LPMC_VLP_RUN: begin
                c.core_clk_en = 1'b1;
                c.periph_clk_en = 1'b1;
                c.reduced_freq = 1'b1;
                c.nested_vector_irq_ctrl_clk_en = 1'b1;
                c.async_wake_irq_ctrl_en = 1'b0;
                c.lvd_en = 1'b0;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b1;
                c.osc_en = 1'b1;
                c.periodic_interval_timer_clk_en = 1'b1;
                c.flexible_io_unit_clk_en = 1'b1;
                c.serial_clk_en = 1'b1;
                c.dma_clk_en = 1'b1;
            end
            lpmc_pkg::LPMC_WAIT: begin
                c.core_clk_en = 1'b0;
                c.periph_clk_en = 1'b1;
                c.reduced_freq = 1'b0;
                c.nested_vector_irq_ctrl_clk_en = 1'b1;
                c.async_wake_irq_ctrl_en = 1'b0;
                c.lvd_en = 1'b1;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b1;
                c.osc_en = 1'b1;
                c.periodic_interval_timer_clk_en = 1'b1;
                c.flexible_io_unit_clk_en = 1'b1;
                c.serial_clk_en = 1'b1;
                c.dma_clk_en = 1'b1;
            end
            lpmc_pkg::LPMC_VLP_WAIT: begin
                c.core_clk_en = 1'b0;
                c.periph_clk_en = 1'b1;
                c.reduced_freq = 1'b1;
                c.nested_vector_irq_ctrl_clk_en = 1'b1;
                c.async_wake_irq_ctrl_en = 1'b0;
                c.lvd_en = 1'b0;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b1;
                c.osc_en = 1'b1;
                c.periodic_interval_timer_clk_en = 1'b1;
                c.flexible_io_unit_clk_en = 1'b1;
                c.serial_clk_en = 1'b1;
                c.dma_clk_en = 1'b1;
            end
            lpmc_pkg::LPMC_STOP: begin
                c.core_clk_en = 1'b0;
                c.periph_clk_en = 1'b0;
                c.reduced_freq = 1'b0;
                c.nested_vector_irq_ctrl_clk_en = 1'b0;
                c.async_wake_irq_ctrl_en = 1'b1;
                c.lvd_en = 1'b1;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b1;
                c.osc_en = 1'b0;
                c.periodic_interval_timer_clk_en = 1'b0;
                c.flexible_io_unit_clk_en = 1'b0;
                c.serial_clk_en = 1'b0;
                c.dma_clk_en = 1'b0;
            end
            lpmc_pkg::LPMC_VLP_STOP: begin
                c.core_clk_en = 1'b0;
                c.periph_clk_en = 1'b0;
                c.reduced_freq = 1'b1;
                c.nested_vector_irq_ctrl_clk_en = 1'b0;
                c.async_wake_irq_ctrl_en = 1'b1;
                c.lvd_en = 1'b0;
                c.sram_retain = 1'b1;
                c.adc_clk_en = 1'b1;
                c.cmp_clk_en = 1'b1;
                c.low_power_timer_clk_en = 1'b1;
                c.rtc_clk_en = 1'b1;
                c.pin_irq_en = 1'b0;
                c.osc_en = 1'b1;
                c.periodic_interval_timer_clk_en = 1'b1;
                c.flexible_io_unit_clk_en = 1'b1;
                c.serial_clk_en = 1'b1;
                c.dma_clk_en = 1'b1;
            end
            default: begin
                c = lpmc_pkg::LPMC_CTRL_RST;
            end
        endcase
        return c;
    endfunction : mode_ctrl

    // Unknown codes block too: refusing a write is the safe side
    function automatic logic mode_blocks(input lpmc_pkg::lpmc_mode_t m);
        logic b;
        b = 1'b1;
        case (m)
            lpmc_pkg::LPMC_RUN: b = 1'b0;
            lpmc_pkg::LPMC_WAIT: b = 1'b0;
            lpmc_pkg::LPMC_STOP: b = 1'b0;
            lpmc_pkg::LPMC_VLP_RUN: b = 1'b1;
            lpmc_pkg::LPMC_VLP_WAIT: b = 1'b1;
            lpmc_pkg::LPMC_VLP_STOP: b = 1'b1;
            lpmc_pkg::LPMC_HS_RUN: b = 1'b1;
            default: b = 1'b1;
        endcase
        return b;
    endfunction : mode_blocks

    function automatic lpmc_pkg::lpmc_mode_t cfg_mode(input lpmc_pkg::lpmc_runcfg_t r);
        lpmc_pkg::lpmc_mode_t m;
        case (r)
            lpmc_pkg::LPMC_CFG_VLP: m = lpmc_pkg::LPMC_VLP_RUN;
            lpmc_pkg::LPMC_CFG_HS: m = lpmc_pkg::LPMC_HS_RUN;
            default: m = lpmc_pkg::LPMC_RUN;
        endcase
        return m;
    endfunction : cfg_mode

    // ****************************************
    // Mode sequencing
    // ****************************************
    always_comb begin
        lpmc_pkg::lpmc_mode_t target;
        target = lpmc_pkg::LPMC_RUN;
        next_st = st;
        next_st.clk_restart_req = 1'b0;
        case (st.mode)
            lpmc_pkg::LPMC_RUN, lpmc_pkg::LPMC_VLP_RUN, lpmc_pkg::LPMC_HS_RUN: begin
                if (wait_for_interrupt_insn_i || wait_for_event_insn_i) begin
                    // deep-sleep selects stop class, VLP run selects VLP flavour
                    next_st.resume_mode = st.mode;
                    if (sleep_deep_i) begin
                        target = (st.mode == lpmc_pkg::LPMC_VLP_RUN) ?
                            lpmc_pkg::LPMC_VLP_STOP : lpmc_pkg::LPMC_STOP;
                    end else begin
                        target = (st.mode == lpmc_pkg::LPMC_VLP_RUN) ?
                            lpmc_pkg::LPMC_VLP_WAIT : lpmc_pkg::LPMC_WAIT;
                    end
                    next_st.mode = target;
                end else begin
                    // Run configuration only changes while awake
                    next_st.mode = cfg_mode(run_cfg_i);
                end
            end
            lpmc_pkg::LPMC_WAIT, lpmc_pkg::LPMC_VLP_WAIT: begin
                if (nested_vector_irq_ctrl_irq_pending_i) begin
                    next_st.mode = st.resume_mode;
                end
            end
            lpmc_pkg::LPMC_STOP, lpmc_pkg::LPMC_VLP_STOP: begin
                // Vectored controller is unclocked; only the wake controller counts
                if (async_wake_event_i) begin
                    next_st.clk_restart_req = 1'b1;
                end
                if (clk_restarted_i && (async_wake_event_i || st.clk_restart_req)) begin
                    next_st.mode = st.resume_mode;
                    next_st.clk_restart_req = 1'b0;
                end else if (st.clk_restart_req) begin
                    next_st.clk_restart_req = 1'b1;
                end
            end
            default: begin
                next_st.mode = lpmc_pkg::LPMC_RUN;
            end
        endcase
        next_st.ctrl = mode_ctrl(next_st.mode);
        next_st.eeprom_wr_block = mode_blocks(next_st.mode);
        next_st.flash_cmd_block = next_st.eeprom_wr_block;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        // Hold all state at reset until the release has crossed both sync flops
        if (!st.rst_sync[1]) begin
            next_st = ST_RST;
            next_st.rst_sync = {st.rst_sync[0], 1'b1};
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Assertion is asynchronous; release is paced by the sync chain above
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign mode_o = st.mode;
    assign ctrl_o = st.ctrl;
    assign eeprom_wr_block_o = st.eeprom_wr_block;
    assign flash_cmd_block_o = st.flash_cmd_block;
    assign clk_restart_req_o = st.clk_restart_req;

endmodule : lpmc_power_mode_ctrl

// >>> rtl/lpmc_pkg.sv
package lpmc_pkg;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [2:0] {
        LPMC_RUN = 3'h0,
        LPMC_VLP_RUN = 3'h1,
        LPMC_WAIT = 3'h2,
        LPMC_VLP_WAIT = 3'h3,
        LPMC_STOP = 3'h4,
        LPMC_VLP_STOP = 3'h5,
        LPMC_HS_RUN = 3'h6
    } lpmc_mode_t;

    // Run configuration requested by software
    typedef enum logic [1:0] {
        LPMC_CFG_RUN = 2'h0,
        LPMC_CFG_VLP = 2'h1,
        LPMC_CFG_HS = 2'h2
    } lpmc_runcfg_t;

    // ****************************************
    // Clock and power enables
    // ****************************************
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic reduced_freq;
        logic nested_vector_irq_ctrl_clk_en;
        logic async_wake_irq_ctrl_en;
        logic lvd_en;
        logic sram_retain;
        logic adc_clk_en;
        logic cmp_clk_en;
        logic low_power_timer_clk_en;
        logic rtc_clk_en;
        logic pin_irq_en;
        logic osc_en;
        logic periodic_interval_timer_clk_en;
        logic flexible_io_unit_clk_en;
        logic serial_clk_en;
        logic dma_clk_en;
    } lpmc_ctrl_t;

    localparam lpmc_ctrl_t LPMC_CTRL_RST = '{
        core_clk_en: 1'b1, periph_clk_en: 1'b1, reduced_freq: 1'b0,
        nested_vector_irq_ctrl_clk_en: 1'b1, async_wake_irq_ctrl_en: 1'b0, lvd_en: 1'b1, sram_retain: 1'b1,
        adc_clk_en: 1'b1, cmp_clk_en: 1'b1, low_power_timer_clk_en: 1'b1,
        rtc_clk_en: 1'b1, pin_irq_en: 1'b1, osc_en: 1'b1,
        periodic_interval_timer_clk_en: 1'b1, flexible_io_unit_clk_en: 1'b1, serial_clk_en: 1'b1,
        dma_clk_en: 1'b1
    };

    typedef struct packed {
        lpmc_mode_t mode;
        lpmc_mode_t resume_mode;
        lpmc_ctrl_t ctrl;
        logic eeprom_wr_block;
        logic flash_cmd_block;
        logic clk_restart_req;
        logic [1:0] rst_sync;
    } lpmc_state_t;

endpackage : lpmc_pkg

// >>> verification/lpmc_sva.sv
`timescale 1ns/1ps
module lpmc_sva (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire lpmc_pkg::lpmc_runcfg_t run_cfg_i,
    input wire logic sleep_deep_i,
    input wire logic wait_for_interrupt_insn_i,
    input wire logic wait_for_event_insn_i,
    input wire logic nested_vector_irq_ctrl_irq_pending_i,
    input wire logic async_wake_event_i,
    input wire logic clk_restarted_i,
    input wire lpmc_pkg::lpmc_mode_t mode_o,
    input wire lpmc_pkg::lpmc_ctrl_t ctrl_o,
    input wire logic eeprom_wr_block_o,
    input wire logic flash_cmd_block_o,
    input wire logic clk_restart_req_o
);
    lpmc_pkg::lpmc_ctrl_t c;
    logic wt, stp, run, vlp;
    logic [2:0] tgt;
    // Class sits in mode bits 2:1
    assign wt = mode_o[2:1] == 2'h1;
    assign stp = mode_o[2:1] == 2'h2;
    assign run = !wt && !stp;
    assign vlp = mode_o inside {3'h1, 3'h3, 3'h5};
    assign c = ctrl_o;
    assign tgt = {sleep_deep_i, !sleep_deep_i, mode_o == lpmc_pkg::LPMC_VLP_RUN};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ********
    // Assertions and covers
    // ********
    a_sleep_entry: assert property (run && (wait_for_interrupt_insn_i ||
        wait_for_event_insn_i) |=> mode_o == $past(tgt)) else $error("bad sleep entry");
    a_run_full: assert property (run |-> c.core_clk_en && c.periph_clk_en &&
        c.reduced_freq == vlp && c.lvd_en == !vlp) else $error("bad run enables");
    a_wait_core: assert property (wt |-> !c.core_clk_en && c.periph_clk_en &&
        c.nested_vector_irq_ctrl_clk_en && c.reduced_freq == vlp && !(vlp && c.lvd_en)) else $error("bad wait");
    a_stop_gate: assert property (mode_o == lpmc_pkg::LPMC_STOP |->
        !c.core_clk_en && !c.periph_clk_en && !c.nested_vector_irq_ctrl_clk_en && c.async_wake_irq_ctrl_en && c.lvd_en &&
        &{c.sram_retain, c.adc_clk_en, c.cmp_clk_en, c.low_power_timer_clk_en, c.rtc_clk_en, c.pin_irq_en})
        else $error("bad stop enables");
    a_very_low_power_stop_keep: assert property (mode_o == lpmc_pkg::LPMC_VLP_STOP |->
        !c.nested_vector_irq_ctrl_clk_en && !c.lvd_en && !c.core_clk_en && c.async_wake_irq_ctrl_en && &{c.sram_retain,
        c.cmp_clk_en, c.adc_clk_en, c.osc_en, c.rtc_clk_en, c.low_power_timer_clk_en, c.periodic_interval_timer_clk_en,
        c.flexible_io_unit_clk_en, c.serial_clk_en, c.dma_clk_en}) else $error("bad vlp stop enables");
    a_block_flags: assert property (eeprom_wr_block_o == (vlp || mode_o == 3'h6) &&
        flash_cmd_block_o == eeprom_wr_block_o) else $error("bad block flags");
    a_wait_wake: assert property (wt && nested_vector_irq_ctrl_irq_pending_i |=> run)
        else $error("no wake from wait");
    a_stop_hold: assert property (stp && nested_vector_irq_ctrl_irq_pending_i && !async_wake_event_i &&
        !clk_restart_req_o |=> $stable(mode_o)) else $error("stop left without wake");
    a_wake_req: assert property (stp && (async_wake_event_i || clk_restart_req_o) &&
        !clk_restarted_i |=> clk_restart_req_o && stp) else $error("restart request missing");
    a_wake_return: assert property (stp && clk_restarted_i && (async_wake_event_i ||
        clk_restart_req_o) |=> run && !clk_restart_req_o) else $error("no return from stop");
    c_wait_wake: cover property (wt && nested_vector_irq_ctrl_irq_pending_i);
    c_slow_restart: cover property (clk_restart_req_o [*4]);
    c_vlp_stop: cover property (mode_o == lpmc_pkg::LPMC_VLP_STOP);
endmodule : lpmc_sva
bind lpmc_power_mode_ctrl lpmc_sva lpmc_sva_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .run_cfg_i(run_cfg_i), .sleep_deep_i(sleep_deep_i),
    .wait_for_interrupt_insn_i(wait_for_interrupt_insn_i),
    .wait_for_event_insn_i(wait_for_event_insn_i), .nested_vector_irq_ctrl_irq_pending_i(nested_vector_irq_ctrl_irq_pending_i),
    .async_wake_event_i(async_wake_event_i), .clk_restarted_i(clk_restarted_i),
    .mode_o(mode_o), .ctrl_o(ctrl_o), .eeprom_wr_block_o(eeprom_wr_block_o),
    .flash_cmd_block_o(flash_cmd_block_o), .clk_restart_req_o(clk_restart_req_o));

// >>> verification/lpmc_core_model.sv
`timescale 1ns/1ps
module lpmc_core_model (
    input wire logic mclk_i,
    input wire logic in_stop_i,
    input wire logic restart_req_i,
    input wire logic [3:0] restart_dly_i,
    output logic wfi_o = 1'b0,
    output logic wfe_o = 1'b0,
    output logic wake_o = 1'b0,
    output logic restarted_o = 1'b1
);
    logic [3:0] cnt = 4'h0;
    // Clocks die in stop and return a set delay after the request
    always @(posedge mclk_i) begin
        cnt <= restart_req_i ? cnt + 4'h1 : 4'h0;
        if (restart_req_i && cnt >= restart_dly_i)
            restarted_o <= #1 1'b1;
        else if (in_stop_i && !restart_req_i)
            restarted_o <= #1 1'b0;
    end
    task automatic sleep(input logic ev);
        @(posedge mclk_i);
        #1 {wfi_o, wfe_o} = {!ev, ev};
        @(posedge mclk_i);
        #1 {wfi_o, wfe_o} = 2'h0;
    endtask : sleep
    task automatic wake();
        @(posedge mclk_i);
        #1 wake_o = 1'b1;
        @(posedge mclk_i);
        #1 wake_o = 1'b0;
    endtask : wake
endmodule : lpmc_core_model

// >>> verification/lpmc_power_mode_ctrl_tb.sv
`timescale 1ns/1ps
module lpmc_power_mode_ctrl_tb;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sleep_deep_i = 1'b0;
    logic nested_vector_irq_ctrl_irq_pending_i = 1'b0;
    logic wait_for_interrupt_insn_i, wait_for_event_insn_i, async_wake_event_i;
    logic clk_restarted_i, eeprom_wr_block_o, flash_cmd_block_o, clk_restart_req_o, stp;
    logic [3:0] dly = 4'h0;
    logic [9:0] row;
    lpmc_pkg::lpmc_runcfg_t run_cfg_i = lpmc_pkg::LPMC_CFG_RUN;
    lpmc_pkg::lpmc_mode_t mode_o;
    lpmc_pkg::lpmc_ctrl_t ctrl_o;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    // Config, deep, event insn, run mode, sleep mode
    logic [9:0] rows [6] = '{10'b00_0_0_000_010, 10'b00_1_1_000_100, 10'b01_0_1_001_011,
        10'b01_1_0_001_101, 10'b10_0_0_110_010, 10'b10_1_1_110_100};
    assign stp = mode_o[2:1] == 2'h2;
    lpmc_power_mode_ctrl lpmc_power_mode_ctrl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .run_cfg_i(run_cfg_i), .sleep_deep_i(sleep_deep_i),
        .wait_for_interrupt_insn_i(wait_for_interrupt_insn_i),
        .wait_for_event_insn_i(wait_for_event_insn_i), .nested_vector_irq_ctrl_irq_pending_i(nested_vector_irq_ctrl_irq_pending_i),
        .async_wake_event_i(async_wake_event_i), .clk_restarted_i(clk_restarted_i),
        .mode_o(mode_o), .ctrl_o(ctrl_o), .eeprom_wr_block_o(eeprom_wr_block_o),
        .flash_cmd_block_o(flash_cmd_block_o), .clk_restart_req_o(clk_restart_req_o));
    lpmc_core_model lpmc_core_model_inst (.mclk_i(mclk_i), .in_stop_i(stp),
        .restart_req_i(clk_restart_req_o), .restart_dly_i(dly),
        .wfi_o(wait_for_interrupt_insn_i), .wfe_o(wait_for_event_insn_i),
        .wake_o(async_wake_event_i), .restarted_o(clk_restarted_i));
    initial forever #5 mclk_i = !mclk_i;
    // Whole run is under a hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Only the enables each mode pins down are compared
    function automatic logic [33:0] ctl_exp(input logic [2:0] m);
        case (m)
            3'h1: return {17'h1e800, 17'h1e000};
            3'h2: return {17'h1e000, 17'h0a000};
            3'h3: return {17'h1e800, 17'h0e000};
            3'h4: return {17'h1bfe0, 17'h01fe0};
            3'h5: return {17'h1bfdf, 17'h017df};
            default: return {17'h1e800, 17'h1a800};
        endcase
    endfunction : ctl_exp
    task automatic chk_mode(input logic [2:0] m);
        logic [33:0] e;
        e = ctl_exp(m);
        chk(17'(mode_o), 17'(m));
        chk(ctrl_o & e[33:17], e[16:0]);
        chk(17'({eblk(), flash_cmd_block_o}), {15'h0, {2{m inside {3'h1, 3'h3, 3'h5, 3'h6}}}});
    endtask : chk_mode
    function automatic logic eblk();
        return eeprom_wr_block_o;
    endfunction : eblk
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic wake_up(input logic [2:0] back);
        if (stp) begin
            lpmc_core_model_inst.wake();
            chk(17'(clk_restart_req_o), 17'h1);
            for (int k = 0; k < 20 && stp; k++) step(1);
            chk(17'(clk_restart_req_o), 17'h0);
        end else begin
            nested_vector_irq_ctrl_irq_pending_i = 1'b1;
            step(1);
            nested_vector_irq_ctrl_irq_pending_i = 1'b0;
        end
        chk_mode(back);
    endtask : wake_up
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // ********
    // Scenarios
    // ********
    initial begin
        step(10);
        rstn_i = 1'b1;
        step(3);
        chk(ctrl_o, lpmc_pkg::LPMC_CTRL_RST);
        foreach (rows[i]) begin
            row = rows[i];
            run_cfg_i = lpmc_pkg::lpmc_runcfg_t'(row[9:8]);
            sleep_deep_i = row[7];
            dly = (i == 3) ? 4'h5 : 4'h0;
            step(2);
            chk_mode(row[5:3]);
            lpmc_core_model_inst.sleep(row[6]);
            chk_mode(row[2:0]);
            wake_up(row[5:3]);
        end
        // Stop ignores the vectored path and config changes, wait ignores extra sleeps
        run_cfg_i = lpmc_pkg::LPMC_CFG_RUN;
        step(2);
        lpmc_core_model_inst.sleep(1'b0);
        nested_vector_irq_ctrl_irq_pending_i = 1'b1;
        run_cfg_i = lpmc_pkg::LPMC_CFG_VLP;
        lpmc_core_model_inst.sleep(1'b1);
        step(2);
        chk_mode(3'h4);
        nested_vector_irq_ctrl_irq_pending_i = 1'b0;
        wake_up(3'h0);
        step(2);
        chk_mode(3'h1);
        sleep_deep_i = 1'b0;
        lpmc_core_model_inst.sleep(1'b0);
        sleep_deep_i = 1'b1;
        lpmc_core_model_inst.sleep(1'b1);
        chk_mode(3'h3);
        wake_up(3'h1);
        // Reset in mid stop
        lpmc_core_model_inst.sleep(1'b1);
        chk_mode(3'h5);
        rstn_i = 1'b0;
        #1;
        chk(ctrl_o, lpmc_pkg::LPMC_CTRL_RST);
        chk_mode(3'h0);
        step(1);
        rstn_i = 1'b1;
        step(2);
        chk_mode(3'h0);
        step(2);
        chk_mode(3'h1);
        end_of_test();
    end
endmodule : lpmc_power_mode_ctrl_tb
